// ==== test/wkb_dma_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Behavioural model of the four-channel DMA controller beside the block.
module wkb_dma_model (
    input  wire logic       sys_clk,
    input  wire logic       dma_reset_out,
    input  wire logic       dma_bus_grant,
    input  wire logic [3:0] req_cmd,
    input  wire logic [3:0] tc_cmd,
    output logic      [7:0] dma_channel_status,
    output logic            dma_address_enable,
    output logic            dma_hold_request,
    output logic      [3:0] dma_tc_ch,
    output logic            dma_mem_to_mem
);
    logic [3:0] tc_seen = 4'h0;
    // Terminal counts stick in the channel status until reset clears them.
    always_ff @(posedge sys_clk) begin
        if (dma_reset_out) begin
            tc_seen <= 4'h0;
        end else begin
            tc_seen <= tc_seen | tc_cmd;
        end
    end
    // A controller held in reset drives all of its status low.
    assign dma_hold_request   = !dma_reset_out && (|req_cmd);
    assign dma_address_enable = dma_hold_request && dma_bus_grant;
    assign dma_channel_status = dma_reset_out ? 8'h00 : {req_cmd, tc_seen};
    assign dma_tc_ch          = dma_reset_out ? 4'h0 : tc_cmd;
    assign dma_mem_to_mem     = 1'b0;
endmodule // wkb_dma_model
`default_nettype wire

// ==== test/wkb_regs_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the wake capture and DMA sideband registers.
module wkb_regs_tb;
    import wkb_pkg::*;
    logic        sys_clk = 1'b0;
    logic        srst    = 1'b1;
    logic [16:0] adr     = '0;
    logic        rd_en   = 1'b0;
    logic        wr_en   = 1'b0;
    logic [31:0] wdat    = '0;
    logic [31:0] rdat;
    logic        wait_rq;
    logic        usb_rst = 1'b0;
    logic        usb_res = 1'b0;
    logic [3:0]  ext     = 4'h0;
    logic [7:0]  smask   = 8'hff;
    logic        dclr    = 1'b0;
    logic        pclr    = 1'b0;
    logic [3:0]  req_cmd = 4'h0;
    logic [3:0]  tc_cmd  = 4'h0;
    logic [7:0]  cstat;
    logic [3:0]  tc_ch;
    logic        aen_in, hold_in, m2m, eop, drst, grant, oe_n;
    logic        dflag, pwr, int_b, restart, ring, xtal;
    int          failures  = 0;
    int          tests_run = 0;

    // The clock runs at 10 MHz.
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    wkb_regs wkb_regs_i (
        .sys_clk(sys_clk), .srst(srst), .avs_address(adr), .avs_read(rd_en),
        .avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(4'h1),
        .avs_readdata(rdat), .avs_waitrequest(wait_rq),
        .usb_reset_detect(usb_rst), .usb_resume_detect(usb_res),
        .ext_int_in_0(ext[0]), .ext_int_in_1(ext[1]),
        .ext_int_in_2(ext[2]), .ext_int_in_3(ext[3]),
        .dma_channel_status(cstat), .dma_status_mask(smask),
        .dma_address_enable(aen_in), .dma_hold_request(hold_in),
        .dma_tc_ch(tc_ch), .dma_mem_to_mem(m2m),
        .dma_done_int_clear(dclr), .power_wake_int_clear(pclr),
        .end_of_process_line(eop), .dma_reset_out(drst),
        .dma_bus_grant(grant), .isa_shared_oe_n(oe_n),
        .dma_done_int_flag(dflag), .power_wake_int_flag(pwr),
        .core_ext_int_line_b(int_b), .core_wake_restart(restart),
        .ring_osc_enable(ring), .xtal_osc_enable(xtal)
    );

    wkb_dma_model wkb_dma_model_i (
        .sys_clk(sys_clk), .dma_reset_out(drst), .dma_bus_grant(grant),
        .req_cmd(req_cmd), .tc_cmd(tc_cmd), .dma_channel_status(cstat),
        .dma_address_enable(aen_in), .dma_hold_request(hold_in),
        .dma_tc_ch(tc_ch), .dma_mem_to_mem(m2m)
    );

    // Counts one comparison and reports a mismatch.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One access, held until waitrequest is sampled low at a rising edge.
    task automatic acc(input logic w, input logic [14:0] idx, input logic [7:0] d,
                       output logic [7:0] q);
        adr   <= {idx, 2'b00};
        wdat  <= {24'h0, d};
        wr_en <= w;
        rd_en <= !w;
        // Waits out every wait state; only the watchdog ends a hang.
        do begin
            @(posedge sys_clk);
        end while (wait_rq !== 1'b0);
        q = rdat[7:0];
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [14:0] idx, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, idx, d, q);
    endtask

    task automatic rd(input string what, input logic [14:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        acc(1'b0, idx, 8'h00, q);
        chk(what, exp, q);
    endtask

    task automatic clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Pulses the power flag clear for one cycle.
    task automatic clr_pwr();
        pclr <= 1'b1;
        clk(1);
        pclr <= 1'b0;
        clk(2);
    endtask

    task automatic t_reset();
        rd("usb mask", IDX_USB_MASK, 8'h06);
        rd("ext mask", IDX_EXT_MASK, 8'h0f);
        rd("bus req", IDX_BUS_REQ, 8'h00);
        rd("ext src", IDX_EXT_SRC, 8'h00);
        wr(15'h7f71, 8'hff);
        rd("unmapped", 15'h7f71, 8'h00);
        wr(IDX_USB_MASK, 8'hff);
        rd("usb mask wr", IDX_USB_MASK, 8'h06);
        wr(IDX_EXT_MASK, 8'hff);
        rd("ext mask wr", IDX_EXT_MASK, 8'h0f);
        $display("test reset values done");
    endtask

    task automatic t_ext();
        ext <= 4'h2;
        clk(6);
        chk("masked pwr", 8'h00, {7'h0, pwr});
        rd("ext src one", IDX_EXT_SRC, 8'h02);
        rd("ext src clr", IDX_EXT_SRC, 8'h00);
        wr(IDX_EXT_MASK, 8'h00);
        ext <= 4'hd;
        clk(6);
        chk("pwr flag", 8'h01, {7'h0, pwr});
        chk("wake outs", 8'h0f, {4'h0, int_b, restart, ring, xtal});
        rd("ext src all", IDX_EXT_SRC, 8'h0f);
        rd("ext src clr2", IDX_EXT_SRC, 8'h00);
        clr_pwr();
        chk("pwr cleared", 8'h00, {7'h0, pwr});
        wr(IDX_EXT_MASK, 8'h0f);
        $display("test external edges done");
    endtask

    task automatic t_usb();
        wr(IDX_USB_MASK, 8'h00);
        usb_rst <= 1'b1;
        clk(6);
        chk("usb pwr", 8'h01, {7'h0, int_b});
        rd("usb src rst", IDX_USB_SRC, 8'h04);
        usb_rst <= 1'b0;
        clk(6);
        rd("usb src fall", IDX_USB_SRC, 8'h00);
        usb_res <= 1'b1;
        clk(6);
        rd("usb src res", IDX_USB_SRC, 8'h02);
        rd("usb src clr", IDX_USB_SRC, 8'h00);
        clr_pwr();
        wr(IDX_USB_MASK, 8'h06);
        usb_rst <= 1'b1;
        clk(6);
        chk("usb masked", 8'h00, {7'h0, pwr});
        rd("usb src msk", IDX_USB_SRC, 8'h04);
        $display("test usb wake done");
    endtask

    task automatic t_bus();
        wr(IDX_BUS_REQ, 8'hff);
        clk(3);
        chk("hold grant", 8'h07, {5'h0, drst, grant, oe_n});
        rd("bus req all", IDX_BUS_REQ, 8'hfa);
        wr(IDX_BUS_REQ, 8'h02);
        req_cmd <= 4'h1;
        clk(4);
        chk("rst release", 8'h00, {7'h0, drst});
        rd("bus req live", IDX_BUS_REQ, 8'h07);
        wr(IDX_BUS_REQ, 8'h00);
        clk(3);
        chk("ungranted", 8'h00, {6'h0, grant, oe_n});
        rd("bus req hold", IDX_BUS_REQ, 8'h01);
        tc_cmd <= 4'h1;
        clk(3);
        chk("eop pass", 8'h01, {7'h0, eop});
        wr(IDX_BUS_REQ, 8'h10);
        clk(2);
        chk("eop inh", 8'h00, {7'h0, eop});
        tc_cmd <= 4'h2;
        clk(3);
        chk("eop ch1", 8'h01, {7'h0, eop});
        tc_cmd <= 4'h0;
        $display("test bus request done");
    endtask

    task automatic t_stat();
        clk(3);
        chk("masked done", 8'h00, {7'h0, dflag});
        rd("bus stat", IDX_BUS_STAT, 8'h13);
        rd("bus stat again", IDX_BUS_STAT, 8'h13);
        smask <= 8'hdf;
        req_cmd <= 4'h3;
        clk(4);
        chk("done flag", 8'h01, {7'h0, dflag});
        rd("bus stat req", IDX_BUS_STAT, 8'h33);
        dclr <= 1'b1;
        clk(1);
        dclr <= 1'b0;
        clk(2);
        chk("done cleared", 8'h00, {7'h0, dflag});
        $display("test bus status done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        results();
    end

    initial begin
        clk(10);
        srst <= 1'b0;
        clk(1);
        t_reset();
        t_ext();
        t_usb();
        t_bus();
        t_stat();
        results();
    end
endmodule // wkb_regs_tb
`default_nettype wire

// ==== verilog/wkb_pkg.sv ====
`default_nettype none
// Shared constants for the wake capture and DMA sideband register block.
package wkb_pkg;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [14:0] IDX_USB_SRC     = 15'h7f2a;
    localparam logic [14:0] IDX_USB_MASK    = 15'h7f2b;
    localparam logic [14:0] IDX_EXT_SRC     = 15'h7f2c;
    localparam logic [14:0] IDX_EXT_MASK    = 15'h7f2d;
    localparam logic [14:0] IDX_BUS_REQ     = 15'h7f70;
    localparam logic [14:0] IDX_BUS_STAT    = 15'h7f73;
    localparam int          ADDR_W          = 17;
    // Field positions.
    localparam int          USB_RESET_BIT   = 2;
    localparam int          USB_RESUME_BIT  = 1;
    localparam int          REQ_INHIBIT_LO  = 4;
    localparam int          REQ_DMA_RST_BIT = 3;
    localparam int          REQ_AEN_BIT     = 2;
    localparam int          REQ_GRANT_BIT   = 1;
    localparam int          REQ_DMA_HOLD_REQUEST_STATUS_BIT    = 0;
    localparam int          NUM_EXT         = 4;
    localparam int          NUM_CELLS       = 6;
    // Writable bits of the two mask registers.
    localparam logic [7:0]  USB_MASK_WR     = 8'h06;
    localparam logic [7:0]  EXT_MASK_WR     = 8'h0f;
    // Reset values.
    localparam logic [7:0]  USB_MASK_RST    = 8'h06;
    localparam logic [7:0]  EXT_MASK_RST    = 8'h0f;
    localparam logic [7:0]  BUS_REQ_RST     = 8'h00;
    // Bus handshake states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DONE = 2'b10
    } wkb_bus_state_t;
endpackage
`default_nettype wire

// ==== verilog/wkb_regs.sv ====
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module wkb_regs
    import wkb_pkg::*;
(
    input  wire logic                       sys_clk,
    input  wire logic                       srst,
    input  wire logic [wkb_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    input  wire logic [3:0]                 avs_byteenable,
    output logic      [31:0]                avs_readdata,
    output logic                            avs_waitrequest,
    input  wire logic                       usb_reset_detect,
    input  wire logic                       usb_resume_detect,
    input  wire logic                       ext_int_in_0,
    input  wire logic                       ext_int_in_1,
    input  wire logic                       ext_int_in_2,
    input  wire logic                       ext_int_in_3,
    input  wire logic [7:0]                 dma_channel_status,
    input  wire logic [7:0]                 dma_status_mask,
    input  wire logic                       dma_address_enable,
    input  wire logic                       dma_hold_request,
    input  wire logic [3:0]                 dma_tc_ch,
    input  wire logic                       dma_mem_to_mem,
    input  wire logic                       dma_done_int_clear,
    input  wire logic                       power_wake_int_clear,
    output logic                            end_of_process_line,
    output logic                            dma_reset_out,
    output logic                            dma_bus_grant,
    output logic                            isa_shared_oe_n,
    output logic                            dma_done_int_flag,
    output logic                            power_wake_int_flag,
    output logic                            core_ext_int_line_b,
    output logic                            core_wake_restart,
    output logic                            ring_osc_enable,
    output logic                            xtal_osc_enable
);
    import wkb_pkg::*;

    wkb_bus_state_t state;
    logic [14:0]    req_idx;
    logic           accept;
    logic           rd_accept;
    logic           wr_accept;
    logic           wr_lane0;
    logic [7:0]     wdata;
    logic [2:1]     usb_src;
    logic [2:1]     usb_mask;
    logic [3:0]     ext_src;
    logic [3:0]     ext_mask;
    logic [3:0]     tc_inhibit;
    logic           dma_reset_hold;
    logic [5:0]     cell_raw;
    logic [5:0]     cell_mask;
    logic [5:0]     cell_edge;
    logic [5:0]     cell_async;
    logic [7:0]     stat_a;
    logic [7:0]     stat_b;
    logic [7:0]     stat_prev;
    logic [1:0]     side_a;
    logic [1:0]     side_b;
    logic           wake_pending;
    logic [7:0]     next_rdata;

    // Selects a register by index; used by the read and the write decode.
    function automatic logic hit(input logic [14:0] idx, input logic [14:0] reg_idx);
        hit = (idx == reg_idx);
    endfunction

    // The request is answered one cycle after it is seen; each access takes two edges.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (avs_read || avs_write) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    assign req_idx         = avs_address[ADDR_W-1:2];
    assign avs_waitrequest = (avs_read || avs_write) && (state != ST_DONE);
    assign accept          = (state == ST_DONE);
    assign rd_accept       = accept && avs_read;
    assign wr_accept       = accept && avs_write;
    assign wr_lane0        = wr_accept && avs_byteenable[0];
    assign wdata           = avs_writedata[7:0];

    // Read mux; reserved and unmapped bits read as zero.
    always_comb begin
        next_rdata = 8'h00;
        if (hit(req_idx, IDX_USB_SRC)) begin
            next_rdata[2:1] = usb_src;
        end else if (hit(req_idx, IDX_USB_MASK)) begin
            next_rdata[2:1] = usb_mask;
        end else if (hit(req_idx, IDX_EXT_SRC)) begin
            next_rdata[3:0] = ext_src;
        end else if (hit(req_idx, IDX_EXT_MASK)) begin
            next_rdata[3:0] = ext_mask;
        end else if (hit(req_idx, IDX_BUS_REQ)) begin
            next_rdata = {tc_inhibit, dma_reset_hold, side_b[1], dma_bus_grant, side_b[0]};
        end else if (hit(req_idx, IDX_BUS_STAT)) begin
            next_rdata = stat_b;
        end
    end

    // Read data is loaded while waiting and stands at the accepting edge.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (state == ST_IDLE && avs_read) begin
            avs_readdata <= {24'h00_0000, next_rdata};
        end
    end

    // Wake inputs: two USB events, rising only, then four pins, either edge.
    assign cell_raw  = {ext_int_in_3, ext_int_in_2, ext_int_in_1, ext_int_in_0,
                        usb_reset_detect, usb_resume_detect};
    assign cell_mask = {ext_mask, usb_mask[USB_RESET_BIT], usb_mask[USB_RESUME_BIT]};

    // One synchronising cell per wake input.
    generate
        for (genvar gi = 0; gi < NUM_CELLS; gi++) begin : g_cell
            wkb_wake_cell #(
                .RISE_ONLY (gi < 2)
            ) u_cell (
                .sys_clk    (sys_clk),
                .srst       (srst),
                .raw_in     (cell_raw[gi]),
                .masked     (cell_mask[gi]),
                .edge_seen  (cell_edge[gi]),
                .async_wake (cell_async[gi])
            );
        end
    endgenerate

    // USB wake source; a read clears only the bits it returned, so an edge that lands
    // between loading the read data and accepting the read is kept for the next read.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            usb_src <= 2'b00;
        end else begin
            usb_src <= (usb_src & ~((rd_accept && hit(req_idx, IDX_USB_SRC)) ?
                                    avs_readdata[2:1] : 2'b00))
                       | {cell_edge[1], cell_edge[0]};
        end
    end

    // Pin wake source: either edge since the last read; reported bits are cleared.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ext_src <= 4'h0;
        end else begin
            ext_src <= (ext_src & ~((rd_accept && hit(req_idx, IDX_EXT_SRC)) ?
                                    avs_readdata[3:0] : 4'h0))
                       | cell_edge[5:2];
        end
    end

    // Mask registers; only the documented bits are writable.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            usb_mask <= USB_MASK_RST[2:1];
            ext_mask <= EXT_MASK_RST[3:0];
        end else if (wr_lane0) begin
            if (hit(req_idx, IDX_USB_MASK)) begin
                usb_mask <= wdata[2:1] & USB_MASK_WR[2:1];
            end
            if (hit(req_idx, IDX_EXT_MASK)) begin
                ext_mask <= wdata[3:0] & EXT_MASK_WR[3:0];
            end
        end
    end

    // Power flag: any enabled source bit, sticky until cleared, set wins.
    assign wake_pending = |(usb_src & ~usb_mask) || |(ext_src & ~ext_mask);
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            power_wake_int_flag <= 1'b0;
        end else begin
            power_wake_int_flag <= (power_wake_int_flag && !power_wake_int_clear)
                                   || wake_pending;
        end
    end

    // The interrupt line follows the flag; a restart also comes from the clockless path.
    assign core_ext_int_line_b = power_wake_int_flag;
    assign core_wake_restart   = power_wake_int_flag || (|cell_async);
    assign ring_osc_enable     = core_wake_restart;
    assign xtal_osc_enable     = core_wake_restart;

    // Request register: inhibits, DMA reset hold and bus grant.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tc_inhibit     <= BUS_REQ_RST[7:4];
            dma_reset_hold <= BUS_REQ_RST[REQ_DMA_RST_BIT];
            dma_bus_grant  <= BUS_REQ_RST[REQ_GRANT_BIT];
        end else if (wr_lane0 && hit(req_idx, IDX_BUS_REQ)) begin
            tc_inhibit     <= wdata[7:REQ_INHIBIT_LO];
            dma_reset_hold <= wdata[REQ_DMA_RST_BIT];
            dma_bus_grant  <= wdata[REQ_GRANT_BIT];
        end
    end

    // Sideband outputs toward the DMA controller and the shared ISA drivers.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dma_reset_out       <= 1'b0;
            isa_shared_oe_n     <= 1'b0;
            end_of_process_line <= 1'b0;
        end else begin
            dma_reset_out       <= dma_reset_hold;
            isa_shared_oe_n     <= dma_bus_grant;
            end_of_process_line <= |(dma_tc_ch & (dma_mem_to_mem ? 4'hf : ~tc_inhibit));
        end
    end

    // Status from the DMA clock domain passes two flops before use.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stat_a <= 8'h00;
            stat_b <= 8'h00;
            side_a <= 2'b00;
            side_b <= 2'b00;
        end else begin
            stat_a <= dma_channel_status;
            stat_b <= stat_a;
            side_a <= {dma_address_enable, dma_hold_request};
            side_b <= side_a;
        end
    end

    // Previous status, for rise detection.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stat_prev <= 8'h00;
        end else begin
            stat_prev <= stat_b;
        end
    end

    // DMA interrupt flag: latched by an enabled rising status bit; set wins over clear.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dma_done_int_flag <= 1'b0;
        end else begin
            dma_done_int_flag <= (dma_done_int_flag && !dma_done_int_clear)
                                 || |(stat_b & ~stat_prev & ~dma_status_mask);
        end
    end

    // A request is answered on the second edge after it rises.
    AST_WAIT_ONE: assert property (@(posedge sys_clk) disable iff (srst)
        (avs_read || avs_write) && state == ST_IDLE |=> !avs_waitrequest)
        else $error("Request not answered in one cycle.");

    // Reading the USB source clears every bit that the read returned.
    AST_USB_RC: assert property (@(posedge sys_clk) disable iff (srst)
        rd_accept && hit(req_idx, IDX_USB_SRC) && cell_edge[1:0] == 2'b00
        |=> (usb_src & $past(avs_readdata[2:1])) == 2'b00)
        else $error("USB wake source not cleared by read.");

    // A USB reset rising event sets its bit.
    AST_USB_SET: assert property (@(posedge sys_clk) disable iff (srst)
        cell_edge[1] |=> usb_src[USB_RESET_BIT])
        else $error("USB reset wake bit not set.");

    // An unmasked pin source bit raises the power flag on the next edge.
    AST_PWR: assert property (@(posedge sys_clk) disable iff (srst)
        |(ext_src & ~ext_mask) |=> power_wake_int_flag && core_ext_int_line_b)
        else $error("Power wake flag missing.");

    // Restart always reopens both oscillators.
    AST_OSC: assert property (@(posedge sys_clk) disable iff (srst)
        core_wake_restart |-> ring_osc_enable && xtal_osc_enable)
        else $error("Oscillators not enabled on restart.");

    // A detected pin change stands in the source register on the next edge, read or not.
    AST_EXT_EDGE: assert property (@(posedge sys_clk) disable iff (srst)
        cell_edge[2] |=> ext_src[0])
        else $error("Pin change not captured.");

    // Pin mask register resets to all masked.
    AST_MASK_RST: assert property (@(posedge sys_clk)
        $past(srst) |-> ext_mask == EXT_MASK_RST[3:0])
        else $error("Pin wake mask reset value wrong.");

    // The reset hold reaches the DMA reset line one edge after the write.
    AST_DMA_RST: assert property (@(posedge sys_clk) disable iff (srst)
        wr_lane0 && hit(req_idx, IDX_BUS_REQ) |=> ##1 dma_reset_out == $past(wdata[3], 2))
        else $error("DMA reset hold not applied.");

    // Granting the bus releases the shared drivers.
    AST_GRANT: assert property (@(posedge sys_clk) disable iff (srst)
        dma_bus_grant |=> isa_shared_oe_n)
        else $error("Shared ISA signals not released on grant.");

    // An inhibited channel never drives end of process outside memory-to-memory cycles.
    AST_INHIBIT: assert property (@(posedge sys_clk) disable iff (srst)
        !dma_mem_to_mem && (dma_tc_ch & ~tc_inhibit) == 4'h0 |=> !end_of_process_line)
        else $error("Inhibited terminal count reached end of process.");

    // A status read returns the synchronised status seen at the loading edge.
    AST_STAT_RD: assert property (@(posedge sys_clk) disable iff (srst)
        rd_accept && hit(req_idx, IDX_BUS_STAT) |-> avs_readdata[7:0] == $past(stat_b))
        else $error("Bus status read data wrong.");

    // An enabled status rise latches the DMA interrupt flag.
    AST_DMA_INT: assert property (@(posedge sys_clk) disable iff (srst)
        |(stat_b & ~stat_prev & ~dma_status_mask) |=> dma_done_int_flag)
        else $error("DMA interrupt flag not latched.");

    // Address enable and hold request read back live after synchronising.
    AST_SIDE_RD: assert property (@(posedge sys_clk) disable iff (srst)
        rd_accept && hit(req_idx, IDX_BUS_REQ)
        |-> avs_readdata[REQ_AEN_BIT] == $past(side_b[1]) && avs_readdata[0] == $past(side_b[0]))
        else $error("Live status bits wrong.");
endmodule // wkb_regs
`default_nettype wire

// ==== verilog/wkb_wake_cell.sv ====
`timescale 1ns/10ps
`default_nettype none
// One wake input: two-flop synchroniser, edge detection and a clockless wake term.
module wkb_wake_cell #(
    parameter bit RISE_ONLY = 1'b1
) (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic raw_in,
    input  wire logic masked,
    output logic      edge_seen,
    output logic      async_wake
);
    logic sync_a;
    logic sync_b;
    logic seen;

    // The first stage is read only by the second stage.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    // Last level that the clocked side has accounted for.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seen <= 1'b0;
        end else begin
            seen <= sync_b;
        end
    end

    // Rising edge only, or either edge, as the input demands.
    assign edge_seen = RISE_ONLY ? (sync_b & ~seen) : (sync_b ^ seen);

    // Without a running clock, an unmasked pin that differs from the last seen level wakes the core; with RISE_ONLY, only a rise does.
    assign async_wake = ~masked & (RISE_ONLY ? (raw_in & ~seen) : (raw_in ^ seen));
endmodule // wkb_wake_cell
`default_nettype wire
